// ===== rtl/scp_gamma_ram.sv
// Purpose: three gamma tables of 1K x 8 in one array
// Assumes: single port, registered read data
// Notes:   colour code 3 addresses nothing; writes to it are dropped, reads give zero
`default_nettype none
module scp_gamma_ram
  import scp_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  scp_lut_if.mem   lut
);
  logic [7:0] mem [LUT_COUNT*LUT_DEPTH];
  logic       in_range;

  assign in_range = (lut.idx < 12'(LUT_COUNT*LUT_DEPTH));

  // table write, no reset so it maps onto block ram
  always_ff @(posedge i_mclk) begin
    if (lut.wr_en && in_range) begin
      mem[lut.idx] <= lut.wdata;
    end
  end

  // registered read data
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lut.rdata <= BYTE_RST;
    end else if (lut.rd_en) begin
      lut.rdata <= in_range ? mem[lut.idx] : BYTE_RST;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/scp_lut_if.sv
// Purpose: port between the pixel path and its gamma table memory
// Assumes: one access per clock, read data one clock later
// Notes:   idx is {colour, 10-bit pixel}
`default_nettype none
interface scp_lut_if;
  logic        wr_en;
  logic        rd_en;
  logic [11:0] idx;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  modport ctrl (output wr_en, output rd_en, output idx, output wdata, input rdata);
  modport mem  (input wr_en, input rd_en, input idx, input wdata, output rdata);
endinterface
`default_nettype wire

// ===== rtl/scp_pixel_path.sv
// Purpose: offset/gain correction, horizontal averaging, output formatting, gamma
//          lookup and sram slot scheduling of the scanner pixel path
// Assumes: at most one sample per 8-clock slot; coefficient word valid with the sample
// Notes:   line start must arrive while no sample is in the pipe
// Behaviour
// - two-byte coefficient, 6 offset 10 gain
// - split bit selects 8 offset 8 gain
// - offset acts on upper ten bits only
// - subtraction clamps at zero
// - multiply corrected word by pixel gain
// - 8-bit gain is top of 10-bit
// - products above 1023 clamp to 1023
// - 8/10-bit modes average adjacent pixels
// - divisor picks 1,1.5,2,3,4,6,8,12
// - output count is integer part; remnants dropped
// - 8-bit averages go through gamma
// - 10-bit pixel sent as two bytes
// - one bit picks full or half duplex
// - full duplex: six sram ops per slot
// - half duplex fill, host reads withheld
// - half duplex readout, two-clock reads
// - 12-bit appends two ADC LSBs
// - 12-bit pixel sent as two bytes
// - three loadable 1K x 8 gamma tables
// - mode A reaches only selected colour table
`default_nettype none
module scp_pixel_path
  import scp_pkg::*;
#(
  parameter int ADC_BITS = ADC_W
) (
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_line_start,
  input  wire logic        i_sample_valid,
  input  wire logic [11:0] i_adc_sample,
  input  wire logic [1:0]  i_channel,
  input  wire logic [15:0] i_coef_word,
  input  wire logic        i_split8,
  input  wire logic        i_offset_en,
  input  wire logic        i_gain_en,
  input  wire logic [1:0]  i_out_mode,
  input  wire logic [2:0]  i_horizontal_divisor,
  input  wire logic        i_duplex_full,
  input  wire logic        i_buffer_full,
  input  wire logic        i_buffer_empty,
  input  wire logic        i_lut_wr,
  input  wire logic        i_lut_rd,
  input  wire logic [1:0]  i_lut_color,
  input  wire logic [9:0]  i_lut_addr,
  input  wire logic [7:0]  i_lut_wdata,
  input  wire logic        i_mode_a,
  input  wire logic [1:0]  i_mode_a_color,
  output logic             o_pix_valid,
  output logic [11:0]      o_pix_data,
  output logic             o_byte_valid,
  output logic             o_byte_first,
  output logic [7:0]       o_byte_data,
  output logic             o_lut_busy,
  output logic             o_lut_rvalid,
  output logic [7:0]       o_lut_rdata,
  output scp_sram_op_e     o_sram_op,
  output logic             o_host_rd_en
);
  if (ADC_BITS != ADC_W) begin : g_bad_adc
    $error("scp_pixel_path serves only 12-bit samples");
  end

  scp_lut_if lut ();

  scp_gamma_ram u_ram (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .lut       (lut.mem)
  );

  // correction pipeline state
  logic       s1_valid, s1_bypass, s2_valid;
  logic [9:0] s1_sub, s1_gain, s2_px;
  logic [1:0] s1_lsb, s1_ch, s2_lsb, s2_ch;
  logic       next_s1_valid, next_s1_bypass, next_s2_valid;
  logic [9:0] next_s1_sub, next_s1_gain, next_s2_px;
  logic [1:0] next_s1_lsb, next_s1_ch, next_s2_lsb, next_s2_ch;
  logic [7:0] off_sel;
  logic [19:0] prod;

  // offset and gain fields come from the split bit; stage 1 subtracts, stage 2 multiplies
  always_comb begin
    off_sel = i_split8 ? i_coef_word[OFF8_LSB +: 8]
                       : {2'h0, i_coef_word[OFF6_LSB +: 6]};
    if (!i_offset_en) begin
      off_sel = 8'h00;
    end
    prod           = 20'(s1_sub) * 20'(s1_gain);
    next_s1_valid  = i_sample_valid;
    next_s1_sub    = s1_sub;
    next_s1_gain   = s1_gain;
    next_s1_lsb    = s1_lsb;
    next_s1_ch     = s1_ch;
    next_s1_bypass = s1_bypass;
    next_s2_valid  = s1_valid;
    next_s2_px     = s2_px;
    next_s2_lsb    = s2_lsb;
    next_s2_ch     = s2_ch;
    if (i_sample_valid) begin
      next_s1_sub    = scp_sat_sub(i_adc_sample[11:2], off_sel);
      next_s1_gain   = i_split8 ? {i_coef_word[7:0], 2'h0}
                                : i_coef_word[GAIN_LSB +: 10];
      next_s1_lsb    = i_adc_sample[1:0];
      next_s1_ch     = i_channel;
      next_s1_bypass = !i_gain_en;
    end
    if (s1_valid) begin
      next_s2_px  = s1_bypass ? s1_sub : ((prod > 20'h003FF) ? PIX_MAX : prod[9:0]);
      next_s2_lsb = s1_lsb;
      next_s2_ch  = s1_ch;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s1_valid <= 1'b0; s1_sub <= 10'h000; s1_gain <= 10'h000; s1_lsb <= 2'h0;
      s1_ch <= 2'h0; s1_bypass <= 1'b0;
      s2_valid <= 1'b0; s2_px <= 10'h000; s2_lsb <= 2'h0; s2_ch <= 2'h0;
    end else begin
      s1_valid <= next_s1_valid; s1_sub <= next_s1_sub; s1_gain <= next_s1_gain;
      s1_lsb <= next_s1_lsb; s1_ch <= next_s1_ch; s1_bypass <= next_s1_bypass;
      s2_valid <= next_s2_valid; s2_px <= next_s2_px; s2_lsb <= next_s2_lsb;
      s2_ch <= next_s2_ch;
    end
  end

  // averaging state, one accumulator per colour so interleaved channels never stall
  logic [13:0] acc [LUT_COUNT];
  logic [3:0]  cnt [LUT_COUNT];
  logic [13:0] next_acc [LUT_COUNT];
  logic [3:0]  next_cnt [LUT_COUNT];
  logic        s3_valid, next_s3_valid;
  logic [11:0] s3_px, next_s3_px;
  logic [1:0]  s3_ch, next_s3_ch;
  logic [13:0] p14;
  logic [3:0]  glen;

  // groups emit only when complete (the 1.5 code emits after its second and third inputs), so a shorter tail never reaches the output
  always_comb begin
    p14           = {4'h0, s2_px};
    glen          = scp_group_len(i_horizontal_divisor);
    next_acc      = acc;
    next_cnt      = cnt;
    next_s3_valid = 1'b0;
    next_s3_px    = s3_px;
    next_s3_ch    = s3_ch;
    if (i_line_start) begin
      for (int c = 0; c < LUT_COUNT; c++) begin
        next_acc[c] = 14'h0000;
        next_cnt[c] = 4'h0;
      end
    end else if (s2_valid && i_out_mode == OUT_MODE_12) begin
      next_s3_valid = 1'b1;
      next_s3_px    = {s2_px, s2_lsb};
      next_s3_ch    = s2_ch;
    end else if (s2_valid && s2_ch < 2'h3) begin
      next_s3_ch = s2_ch;
      if (i_horizontal_divisor == HDIV_1P5) begin
        // three inputs give two outputs weighted 2:1 and 1:2
        unique case (cnt[s2_ch])
          4'h0: begin
            next_acc[s2_ch] = p14 << 1;
            next_cnt[s2_ch] = 4'h1;
          end
          4'h1: begin
            next_s3_valid   = 1'b1;
            next_s3_px      = {2'h0, scp_avg(acc[s2_ch] + p14, HDIV_1P5)};
            next_acc[s2_ch] = p14;
            next_cnt[s2_ch] = 4'h2;
          end
          default: begin
            next_s3_valid   = 1'b1;
            next_s3_px      = {2'h0, scp_avg(acc[s2_ch] + (p14 << 1), HDIV_1P5)};
            next_acc[s2_ch] = 14'h0000;
            next_cnt[s2_ch] = 4'h0;
          end
        endcase
      end else if (cnt[s2_ch] + 4'h1 >= glen) begin
        next_s3_valid   = 1'b1;
        next_s3_px      = {2'h0, scp_avg(acc[s2_ch] + p14, i_horizontal_divisor)};
        next_acc[s2_ch] = 14'h0000;
        next_cnt[s2_ch] = 4'h0;
      end else begin
        next_acc[s2_ch] = acc[s2_ch] + p14;
        next_cnt[s2_ch] = cnt[s2_ch] + 4'h1;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int c = 0; c < LUT_COUNT; c++) begin
        acc[c] <= 14'h0000;
        cnt[c] <= 4'h0;
      end
      s3_valid <= 1'b0; s3_px <= 12'h000; s3_ch <= 2'h0;
    end else begin
      acc <= next_acc; cnt <= next_cnt;
      s3_valid <= next_s3_valid; s3_px <= next_s3_px; s3_ch <= next_s3_ch;
    end
  end

  assign o_pix_valid = s3_valid;
  assign o_pix_data  = s3_px;

  // gamma table port: pixel lookups take priority, one parked host access waits
  logic        pix_rd, host_go;
  logic        host_pend, host_wr, host_rd_wait, lut_rvalid;
  logic [11:0] host_idx;
  logic [7:0]  host_data, lut_rdata;
  logic        next_host_pend, next_host_wr, next_host_rd_wait, next_lut_rvalid;
  logic [11:0] next_host_idx;
  logic [7:0]  next_host_data, next_lut_rdata;
  logic [1:0]  pix_color;

  always_comb begin
    pix_rd    = s3_valid && i_out_mode == OUT_MODE_8;
    pix_color = i_mode_a ? i_mode_a_color : s3_ch;
    host_go   = host_pend && !pix_rd;
    lut.rd_en = pix_rd || (host_go && !host_wr);
    lut.wr_en = host_go && host_wr;
    lut.idx   = pix_rd ? {pix_color, s3_px[9:0]} : host_idx;
    lut.wdata = host_data;
    next_host_pend    = host_pend ? !host_go : (i_lut_wr || i_lut_rd);
    next_host_wr      = host_wr;
    next_host_idx     = host_idx;
    next_host_data    = host_data;
    next_host_rd_wait = host_go && !host_wr;
    next_lut_rvalid   = host_rd_wait;
    next_lut_rdata    = host_rd_wait ? lut.rdata : lut_rdata;
    if (!host_pend && (i_lut_wr || i_lut_rd)) begin
      next_host_wr   = i_lut_wr;
      next_host_idx  = {(i_mode_a ? i_mode_a_color : i_lut_color), i_lut_addr};
      next_host_data = i_lut_wdata;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      host_pend <= 1'b0; host_wr <= 1'b0; host_idx <= 12'h000; host_data <= BYTE_RST;
      host_rd_wait <= 1'b0; lut_rvalid <= 1'b0; lut_rdata <= BYTE_RST;
    end else begin
      host_pend <= next_host_pend; host_wr <= next_host_wr; host_idx <= next_host_idx;
      host_data <= next_host_data; host_rd_wait <= next_host_rd_wait;
      lut_rvalid <= next_lut_rvalid; lut_rdata <= next_lut_rdata;
    end
  end

  assign o_lut_busy   = host_pend;
  assign o_lut_rvalid = lut_rvalid;
  assign o_lut_rdata  = lut_rdata;

  // byte formatter; don't-care bit positions are driven as zero
  logic       gam_pend, lo_pend, byte_valid, byte_first;
  logic [7:0] lo_byte, byte_data;
  logic       next_gam_pend, next_lo_pend, next_byte_valid, next_byte_first;
  logic [7:0] next_lo_byte, next_byte_data;

  always_comb begin
    next_gam_pend   = pix_rd;
    next_lo_pend    = 1'b0;
    next_lo_byte    = lo_byte;
    next_byte_valid = 1'b0;
    next_byte_first = 1'b0;
    next_byte_data  = byte_data;
    if (gam_pend) begin
      next_byte_valid = 1'b1;
      next_byte_first = 1'b1;
      next_byte_data  = lut.rdata;
    end else if (lo_pend) begin
      next_byte_valid = 1'b1;
      next_byte_data  = lo_byte;
    end
    if (s3_valid && i_out_mode != OUT_MODE_8) begin
      next_byte_valid = 1'b1;
      next_byte_first = 1'b1;
      next_lo_pend    = 1'b1;
      if (i_out_mode == OUT_MODE_12) begin
        next_byte_data = {4'h0, s3_px[11:8]};
        next_lo_byte   = s3_px[7:0];
      end else begin
        next_byte_data = {4'h0, s3_px[9:6]};
        next_lo_byte   = {s3_px[5:0], 2'h0};
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      gam_pend <= 1'b0; lo_pend <= 1'b0; lo_byte <= BYTE_RST;
      byte_valid <= 1'b0; byte_first <= 1'b0; byte_data <= BYTE_RST;
    end else begin
      gam_pend <= next_gam_pend; lo_pend <= next_lo_pend; lo_byte <= next_lo_byte;
      byte_valid <= next_byte_valid; byte_first <= next_byte_first;
      byte_data <= next_byte_data;
    end
  end

  assign o_byte_valid = byte_valid;
  assign o_byte_first = byte_first;
  assign o_byte_data  = byte_data;

  // sram slot schedule; mode and phase change only at a slot boundary so no slot is torn
  logic [2:0]   slot, next_slot;
  logic         sched_full, next_sched_full, host_rd_en, next_host_rd_en;
  scp_phase_e   phase, next_phase;
  scp_sram_op_e sram_op, next_sram_op;

  always_comb begin
    next_slot       = slot + 3'h1;
    next_sched_full = sched_full;
    next_phase      = phase;
    if (next_slot == SLOT_RST) begin
      next_sched_full = i_duplex_full;
      if (i_duplex_full || (phase == PH_READOUT && i_buffer_empty)) begin
        next_phase = PH_FILL;
      end else if (i_buffer_full) begin
        next_phase = PH_READOUT;
      end
    end
    next_sram_op    = scp_sched_op(next_slot, next_sched_full, next_phase);
    next_host_rd_en = next_sched_full || next_phase == PH_READOUT;
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      slot <= SLOT_RST; sched_full <= 1'b1; phase <= PH_FILL;
      sram_op <= SOP_OFF_RD; host_rd_en <= 1'b1;
    end else begin
      slot <= next_slot; sched_full <= next_sched_full; phase <= next_phase;
      sram_op <= next_sram_op; host_rd_en <= next_host_rd_en;
    end
  end

  assign o_sram_op    = sram_op;
  assign o_host_rd_en = host_rd_en;

  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  sequence seq_full_ops;
    o_sram_op == SOP_OFF_RD ##1 o_sram_op == SOP_GAIN_RD ##1 o_sram_op == SOP_HI_WR [*2]
    ##1 o_sram_op == SOP_LO_WR [*2] ##1 o_sram_op == SOP_HI_RD ##1 o_sram_op == SOP_LO_RD;
  endsequence
  sequence seq_half_ops;
    o_sram_op == SOP_OFF_RD [*2] ##1 o_sram_op == SOP_GAIN_RD [*2]
    ##1 o_sram_op == SOP_HI_WR [*2] ##1 o_sram_op == SOP_LO_WR [*2];
  endsequence

  // start from the wrap edge so the slot 0 held by reset never opens an attempt
  chk_full_sched_ops: assert property (
    slot == 3'h7 ##1 sched_full |-> seq_full_ops)
    else $error("full duplex slot order wrong");
  chk_half_sched_ops: assert property (
    slot == 3'h7 ##1 (!sched_full && phase == PH_FILL) |-> seq_half_ops)
    else $error("half duplex fill order wrong");
  chk_readout_two_clk: assert property (
    !sched_full && phase == PH_READOUT && !slot[0] |-> o_sram_op == SOP_HOST_RD [*2])
    else $error("readout cycle not two clocks");
  chk_host_read_withheld: assert property (
    !sched_full && phase == PH_FILL |-> !o_host_rd_en && o_sram_op != SOP_HOST_RD)
    else $error("host read during fill");
  chk_offset_clamp_zero: assert property (
    i_sample_valid && off_sel > i_adc_sample[11:2] |=> s1_sub == 10'h000)
    else $error("offset subtract did not clamp");
  chk_gain_pad_split: assert property (
    i_sample_valid && i_split8 |=> s1_gain == {$past(i_coef_word[7:0]), 2'h0})
    else $error("8-bit gain not padded");
  chk_mult_saturate: assert property (
    s1_valid && !s1_bypass && prod > 20'h003FF |=> s2_px == PIX_MAX)
    else $error("product not clamped");
  chk_lsb_rebuild: assert property (
    i_sample_valid ##2 (i_out_mode == OUT_MODE_12 && !i_line_start)
    |=> o_pix_valid && o_pix_data[1:0] == $past(i_adc_sample[1:0], 3))
    else $error("12-bit low bits lost");
  chk_byte_pair_order: assert property (
    s3_valid && i_out_mode == OUT_MODE_10
    |=> o_byte_valid && o_byte_first && o_byte_data == {4'h0, $past(s3_px[9:6])}
    ##1 o_byte_valid && !o_byte_first)
    else $error("10-bit byte pair wrong");
  chk_mode_a_table: assert property (
    i_mode_a && (lut.rd_en || lut.wr_en) |-> lut.idx[11:10] == i_mode_a_color)
    else $error("mode A reached another table");
endmodule
`default_nettype wire

// ===== rtl/scp_pkg.sv
// Purpose: shared constants, types and helpers of the scanner pixel correction path
// Assumes: 12-bit ADC samples, 10-bit corrected pixels, 8 master clocks per pixel slot
// Notes:   the sram schedule function is used by the datapath only; its checks spell out the slot order themselves
`default_nettype none
package scp_pkg;
  // sample and pixel widths
  localparam int ADC_W    = 12;
  localparam int PIX_W    = 10;
  localparam int SUM_W    = 14;
  localparam int COEF_W   = 16;
  localparam logic [9:0] PIX_MAX = 10'h3FF;

  // coefficient word layout: offset in the top bits, gain in the bottom bits
  localparam int GAIN_LSB  = 0;
  localparam int OFF6_LSB  = 10;
  localparam int OFF8_LSB  = 8;
  localparam int GAIN8_PAD = 2;

  // gamma tables
  localparam int LUT_COUNT  = 3;
  localparam int LUT_DEPTH  = 1024;
  localparam int LUT_ADDR_W = 10;
  localparam int LUT_IDX_W  = 12;

  // output modes
  localparam logic [1:0] OUT_MODE_8  = 2'h0;
  localparam logic [1:0] OUT_MODE_10 = 2'h1;
  localparam logic [1:0] OUT_MODE_12 = 2'h2;

  // horizontal divisor code of the 1.5 factor
  localparam logic [2:0] HDIV_1P5 = 3'h1;

  // pixel slot timing in master clocks
  localparam int SLOT_CLKS     = 8;
  localparam int FULL_WR_CLKS  = 2;
  localparam int FULL_RD_CLKS  = 1;
  localparam int HALF_OP_CLKS  = 2;

  // reset values
  localparam logic [2:0] SLOT_RST = 3'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum logic [2:0] {
    SOP_OFF_RD, SOP_GAIN_RD, SOP_HI_WR, SOP_LO_WR, SOP_HI_RD, SOP_LO_RD, SOP_HOST_RD
  } scp_sram_op_e;

  typedef enum logic {PH_FILL, PH_READOUT} scp_phase_e;

  // offset subtract on the upper ten sample bits, saturating at zero
  function automatic logic [9:0] scp_sat_sub(input logic [9:0] a, input logic [7:0] b);
    logic [10:0] d;
    d = {1'b0, a} - {3'h0, b};
    return d[10] ? 10'h000 : d[9:0];
  endfunction

  // samples per averaging group for each divisor code (the 1.5 code uses groups of 3)
  function automatic logic [3:0] scp_group_len(input logic [2:0] code);
    logic [3:0] n;
    unique case (code)
      3'h0:    n = 4'h1;
      3'h1:    n = 4'h3;
      3'h2:    n = 4'h2;
      3'h3:    n = 4'h3;
      3'h4:    n = 4'h4;
      3'h5:    n = 4'h6;
      3'h6:    n = 4'h8;
      default: n = 4'hC;
    endcase
    return n;
  endfunction

  // divide a group sum by the divisor; the 1.5 weights add up to three
  function automatic logic [9:0] scp_avg(input logic [13:0] sum, input logic [2:0] code);
    logic [13:0] q;
    unique case (code)
      3'h0:       q = sum;
      3'h1, 3'h3: q = sum / 14'h0003;
      3'h2:       q = sum >> 1;
      3'h4:       q = sum >> 2;
      3'h5:       q = sum / 14'h0006;
      3'h6:       q = sum >> 3;
      default:    q = sum / 14'h000C;
    endcase
    return q[9:0];
  endfunction

  // sram operation for a slot position
  function automatic scp_sram_op_e scp_sched_op(input logic [2:0] slot, input logic full,
                                                input scp_phase_e ph);
    scp_sram_op_e op;
    if (full) begin
      unique case (slot)
        3'h0:       op = SOP_OFF_RD;
        3'h1:       op = SOP_GAIN_RD;
        3'h2, 3'h3: op = SOP_HI_WR;
        3'h4, 3'h5: op = SOP_LO_WR;
        3'h6:       op = SOP_HI_RD;
        default:    op = SOP_LO_RD;
      endcase
    end else if (ph == PH_READOUT) begin
      op = SOP_HOST_RD;
    end else begin
      unique case (slot[2:1])
        2'h0:    op = SOP_OFF_RD;
        2'h1:    op = SOP_GAIN_RD;
        2'h2:    op = SOP_HI_WR;
        default: op = SOP_LO_WR;
      endcase
    end
    return op;
  endfunction
endpackage
`default_nettype wire

// ===== tb/scp_front_model.sv
// Purpose: adc and coefficient sram as seen by the pixel path
// Assumes: one request pulse per pixel slot
// Notes:   idle lines toggle so a stale value never looks valid
`default_nettype none
module scp_front_model (
  input  wire logic        i_mclk,
  input  wire logic        i_go,
  input  wire logic [11:0] i_code,
  input  wire logic [15:0] i_coef,
  output logic             o_valid,
  output logic [11:0]      o_sample,
  output logic [15:0]      o_coef
);
  timeunit 1ns;
  timeprecision 1ps;
  // sample and its coefficient word come together, once per pixel
  always @(posedge i_mclk) begin
    o_valid <= i_go;
    o_sample <= i_go ? i_code : ~o_sample;
    o_coef <= i_go ? i_coef : ~o_coef;
  end
endmodule
`default_nettype wire

// ===== tb/scp_pixel_path_tb.sv
// Purpose: self-checking bench of the pixel path
// Assumes: one sample per pixel slot
// Notes:   expected values are worked out by hand
`default_nettype none
module scp_pixel_path_tb
  import scp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, ls = 1'b0, go = 1'b0, sv, s8 = 1'b0, oe = 1'b1, ge = 1'b1;
  logic dup = 1'b1, bf = 1'b0, wr = 1'b0, rd = 1'b0, ma = 1'b0, pv, bv, bfst, busy, rv, hre;
  logic        be = 1'b0;
  logic [1:0]  ch = 2'h0, om = 2'h1, lc = 2'h0, mc = 2'h1;
  logic [2:0]  hd = 3'h0;
  logic [7:0]  lw = 8'h00, bd, rdat, b1, b2;
  logic [11:0] code = 12'h000, smp, pd, px;
  logic [15:0] coef = 16'h0000, cw;
  scp_sram_op_e op, pr;
  scp_sram_op_e fo[8] = '{SOP_OFF_RD, SOP_GAIN_RD, SOP_HI_WR, SOP_HI_WR,
                          SOP_LO_WR, SOP_LO_WR, SOP_HI_RD, SOP_LO_RD};
  scp_sram_op_e ho[4] = '{SOP_OFF_RD, SOP_GAIN_RD, SOP_HI_WR, SOP_LO_WR};
  int miscompares = 0, compares = 0;
  scp_front_model fm (.i_mclk(clk), .i_go(go), .i_code(code), .i_coef(coef),
    .o_valid(sv), .o_sample(smp), .o_coef(cw));
  scp_pixel_path uut (.i_mclk(clk), .i_sys_rst(rst), .i_line_start(ls),
    .i_sample_valid(sv), .i_adc_sample(smp), .i_channel(ch), .i_coef_word(cw),
    .i_split8(s8), .i_offset_en(oe), .i_gain_en(ge), .i_out_mode(om),
    .i_horizontal_divisor(hd), .i_duplex_full(dup), .i_buffer_full(bf),
    .i_buffer_empty(be), .i_lut_wr(wr), .i_lut_rd(rd), .i_lut_color(lc),
    .i_lut_addr(10'h05F), .i_lut_wdata(lw), .i_mode_a(ma), .i_mode_a_color(mc),
    .o_pix_valid(pv), .o_pix_data(pd), .o_byte_valid(bv), .o_byte_first(bfst),
    .o_byte_data(bd), .o_lut_busy(busy), .o_lut_rvalid(rv), .o_lut_rdata(rdat),
    .o_sram_op(op), .o_host_rd_en(hre));
  // clock of 5 ns
  always #2.5 clk = ~clk;
  task automatic end_sim;
    if (miscompares == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [11:0] e, input logic [11:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // one sample through the front model; unknown means nothing came out
  task automatic pix(input logic [11:0] s, input logic [15:0] c);
    @(posedge clk);
    go <= 1'b1;
    code <= s;
    coef <= c;
    @(posedge clk);
    go <= 1'b0;
    px = 'x;
    b1 = 'x;
    b2 = 'x;
    repeat (14) begin
      @(posedge clk);
      #1;
      if (pv === 1'b1) px = pd;
      if (bv === 1'b1 && bfst === 1'b1) b1 = bd;
      else if (bv === 1'b1) b2 = bd;
    end
  endtask
  // table write or read at index 95; read data lands in b1
  task automatic lut(input logic w, input logic [1:0] c, input logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= ~w;
    lc <= c;
    lw <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    cmp("busy", 12'h001, {11'h0, busy});
    b1 = 'x;
    repeat (8) begin
      @(posedge clk);
      #1;
      if (rv === 1'b1) b1 = rdat;
    end
    cmp("idle", 12'h000, {11'h0, busy});
  endtask
  // one slot of the sram schedule, eight clocks, aligned on a fresh offset read except in readout
  task automatic sched(input logic full, input logic ro);
    scp_sram_op_e e;
    int n;
    repeat (24) @(posedge clk);
    #1;
    pr = SOP_OFF_RD;
    for (n = 0; n < 40 && !ro && !(op === SOP_OFF_RD && pr !== SOP_OFF_RD); n++) begin
      pr = op;
      @(posedge clk);
      #1;
    end
    if (n == 40) begin
      miscompares++;
      end_sim();
    end
    for (n = 0; n < 8; n++) begin
      e = ro ? SOP_HOST_RD : full ? fo[n] : ho[n / 2];
      cmp("sram op", {9'h0, e}, {9'h0, op});
      cmp("host rd", {11'h0, full | ro}, {11'h0, hre});
      @(posedge clk);
      #1;
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    sched(1'b1, 1'b0);
    @(posedge clk);
    dup <= 1'b0;
    sched(1'b0, 1'b0);
    @(posedge clk);
    bf <= 1'b1;
    sched(1'b0, 1'b1);
    @(posedge clk);
    {bf, be} <= 2'h1;
    sched(1'b0, 1'b0);
    @(posedge clk);
    dup <= 1'b1;
    be <= 1'b0;
    pix(12'h190, 16'h1403);
    cmp("pix", 12'h11D, px);
    cmp("hi byte", 12'h004, {4'h0, b1});
    cmp("lo byte", 12'h074, {4'h0, b2});
    pix(12'h010, 16'h1401);
    cmp("pix", 12'h000, px);
    pix(12'hFFC, 16'h0002);
    cmp("pix", 12'h3FF, px);
    @(posedge clk);
    s8 <= 1'b1;
    pix(12'h4B0, 16'hC801);
    cmp("pix", 12'h190, px);
    @(posedge clk);
    {s8, oe, ge, hd, ls} <= {3'h0, 3'h2, 1'b1};
    @(posedge clk);
    ls <= 1'b0;
    pix(12'h190, 16'h0000);
    cmp("early", 'x, px);
    pix(12'h324, 16'h0000);
    cmp("avg", 12'h096, px);
    @(posedge clk);
    {hd, ls} <= {3'h1, 1'b1};
    @(posedge clk);
    ls <= 1'b0;
    pix(12'h0C8, 16'h0000);
    cmp("1p5 a", 'x, px);
    pix(12'h190, 16'h0000);
    cmp("1p5 b", 12'h042, px);
    pix(12'h258, 16'h0000);
    cmp("1p5 c", 12'h085, px);
    @(posedge clk);
    {om, hd} <= {2'h2, 3'h0};
    pix(12'hABC, 16'h0000);
    cmp("pix", 12'hABC, px);
    cmp("hi byte", 12'h00A, {4'h0, b1});
    cmp("lo byte", 12'h0BC, {4'h0, b2});
    @(posedge clk);
    om <= 2'h0;
    lut(1'b1, 2'h0, 8'h5A);
    pix(12'h17C, 16'h0000);
    cmp("gamma", 12'h05A, {4'h0, b1});
    @(posedge clk);
    ma <= 1'b1;
    lut(1'b1, 2'h0, 8'hC3);
    pix(12'h17C, 16'h0000);
    cmp("mode a", 12'h0C3, {4'h0, b1});
    @(posedge clk);
    ma <= 1'b0;
    lut(1'b0, 2'h1, 8'h00);
    cmp("rd c1", 12'h0C3, {4'h0, b1});
    lut(1'b0, 2'h0, 8'h00);
    cmp("rd c0", 12'h05A, {4'h0, b1});
    end_sim();
  end
endmodule
`default_nettype wire
